// >>> bench/jdra_host.sv
`timescale 1ns/100ps
module jdra_host (
  output logic tck,
  output jdra_pkg::jdra_tap_t tap,
  output jdra_pkg::jdra_ir_t ir,
  output logic test_data_in_pin,
  input wire logic test_data_out_pin
);
  import jdra_pkg::*;
  initial begin
    tck = 1'h0;
    tap = '0;
    ir = '0;
    test_data_in_pin = 1'h0;
  end
  // Link clock runs only inside scans
  task automatic pulse();
    #80 tck = 1'h1;
    #80 tck = 1'h0;
  endtask
  task automatic scan(input jdra_ir_t irv, input int idle, input logic [34:0] din, output logic [34:0] dout);
    ir = irv;
    repeat (idle) pulse();
    tap = 3'h4;
    pulse();
    tap = 3'h2;
    for (int i = 0; i < CHAIN_W; i++) begin
      test_data_in_pin = din[i];
      dout[i] = test_data_out_pin;
      pulse();
    end
    tap = 3'h1;
    pulse();
    tap = 3'h0;
    // Released line shows the inverse, not a stale bit
    test_data_in_pin = ~test_data_in_pin;
  endtask
endmodule  // jdra_host

// >>> bench/jdra_top_asserts.sv
`timescale 1ns/100ps
module jdra_chk (
  input wire logic clk,
  input wire logic nrst,
  input wire logic tck,
  input wire jdra_pkg::jdra_tap_t tap,
  input wire jdra_pkg::jdra_ir_t ir,
  input wire logic test_data_out_pin,
  input wire logic [31:0] ctrl_stat,
  input wire logic ap_req_valid,
  input wire jdra_pkg::jdra_ap_req_t ap_req,
  input wire logic ap_done,
  input wire logic ap_cancel
);
  import jdra_pkg::*;
  logic cap_r;
  logic wait_r;
  // First bit out after capture marks a wait scan
  always_ff @(posedge tck or negedge nrst) begin
    if (!nrst) begin
      cap_r <= 1'h0;
      wait_r <= 1'h0;
    end else begin
      cap_r <= tap.capture && (ir.debug_port_access_chain || ir.access_port_access_chain);
      if (cap_r) begin
        wait_r <= test_data_out_pin;
      end
    end
  end
  sequence s_ok;
    !test_data_out_pin ##1 test_data_out_pin ##1 !test_data_out_pin;
  endsequence
  sequence s_wait;
    test_data_out_pin ##1 !test_data_out_pin ##1 !test_data_out_pin;
  endsequence
  property p_ack;
    @(posedge tck) disable iff (!nrst) tap.capture && (ir.debug_port_access_chain || ir.access_port_access_chain) |=> s_ok or s_wait;
  endproperty
  a_ack: assert property (p_ack) else $error("bad acknowledge");
  property p_orun;
    @(posedge tck) disable iff (!nrst)
      $rose(ctrl_stat[CTRL_STK_ORUN]) |-> $past(tap.capture) && $past(ctrl_stat[CTRL_ORUN_DET]);
  endproperty
  a_orun: assert property (p_orun) else $error("overrun flag set without cause");
  property p_wait_hold;
    @(posedge tck) disable iff (!nrst)
      tap.update && wait_r |=> $stable({ctrl_stat[31:CTRL_STK_ERR+1], ctrl_stat[CTRL_STK_CMP-1:0]});
  endproperty
  a_wait_hold: assert property (p_wait_hold) else $error("update after wait changed state");
  property p_cancel_zero;
    @(posedge tck) disable iff (!nrst) tap.capture && ir.cancel |=> !test_data_out_pin [*3];
  endproperty
  a_cancel_zero: assert property (p_cancel_zero) else $error("cancel chain not zero");
  property p_hold;
    @(posedge clk) disable iff (!nrst)
      ap_req_valid && !ap_done && !ap_cancel |=> (ap_req_valid && $stable(ap_req)) || ap_cancel;
  endproperty
  a_hold: assert property (p_hold) else $error("request dropped early");
  property p_done_drop;
    @(posedge clk) disable iff (!nrst) ap_req_valid && ap_done |=> !ap_req_valid;
  endproperty
  a_done_drop: assert property (p_done_drop) else $error("request held after done");
  property p_cancel_pulse;
    @(posedge clk) disable iff (!nrst) ap_cancel |=> !ap_cancel;
  endproperty
  a_cancel_pulse: assert property (p_cancel_pulse) else $error("cancel longer than one clock");
  property p_cancel_free;
    @(posedge clk) disable iff (!nrst) ap_cancel |-> ##[0:2] !ap_req_valid;
  endproperty
  a_cancel_free: assert property (p_cancel_free) else $error("cancel left request pending");
endmodule  // jdra_chk

// >>> bench/tb_jdra_top.sv
`timescale 1ns/100ps
module tb_jdra_top;
  import jdra_pkg::*;
  localparam int MIN_T = 4;
  localparam logic [31:0] CV = 32'hA5A5_0001;
  localparam logic [31:0] SV = 32'h0300_00F0;
  localparam logic [31:0] WV = 32'hC3C3_5A5A;
  typedef struct packed {jdra_ir_t irv; logic [31:0] d; logic [1:0] a; logic read_not_write_bit; logic [31:0] ed;} jdra_row_t;
  logic clk, nrst, tck, test_data_in_pin, test_data_out_pin, ap_req_valid, ap_done, ap_cancel, vprev, ap_err;
  jdra_tap_t tap;
  jdra_ir_t ir;
  logic [31:0] ctrl_stat, ap_rd;
  jdra_ap_req_t ap_req, last_req;
  jdra_ap_rsp_t ap_rsp;
  logic [34:0] dout;
  int n_mismatch, n_compared, n_req, n_cncl, cnt, ap_dly;
  jdra_row_t rows [7] = '{'{3'h4, CV, 2'h1, 1'h0, 32'h0}, '{3'h4, SV, 2'h2, 1'h0, 32'h0},
    '{3'h4, 32'h0, 2'h1, 1'h1, 32'h0}, '{3'h4, 32'h0, 2'h2, 1'h1, CV}, '{3'h4, 32'h1, 2'h3, 1'h0, SV},
    '{3'h4, 32'h0, 2'h3, 1'h1, 32'h0}, '{3'h4, 32'h0, 2'h1, 1'h1, 32'h0}};
  jdra_top #(.MIN_TCK(MIN_T)) uut (.clk, .nrst, .tck, .tap, .ir, .test_data_in_pin, .test_data_out_pin,
    .ctrl_stat, .ap_req_valid, .ap_req, .ap_done, .ap_rsp, .ap_cancel);
  jdra_host u_host (.tck, .tap, .ir, .test_data_in_pin, .test_data_out_pin);
  initial begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end
  // Access port answers after ap_dly clocks; idle response lines keep toggling
  always @(posedge clk) begin
    vprev <= ap_req_valid;
    ap_done <= 1'h0;
    ap_rsp <= ~ap_rsp;
    n_cncl <= n_cncl + int'(ap_cancel);
    if (ap_req_valid && !vprev) begin
      n_req <= n_req + 1;
      last_req <= ap_req;
    end
    cnt <= 0;
    if (ap_req_valid && !ap_done) begin
      cnt <= cnt + 1;
      if (cnt >= ap_dly) begin
        ap_done <= 1'h1;
        ap_rsp <= {ap_rd, ap_err, ap_err};
      end
    end
  end
  task automatic check(input logic [34:0] seen, input logic [34:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    nrst = 1'h0;
    ap_done = 1'h0;
    ap_rsp = '0;
    ap_rd = 32'h0;
    ap_err = 1'h0;
    ap_dly = 2;
    vprev = 1'h0;
    repeat (6) @(posedge clk);
    nrst <= 1'h1;
    repeat (3) @(posedge clk);
    #37;
    check({3'h0, ctrl_stat}, 35'h0);
    foreach (rows[i]) begin
      u_host.scan(rows[i].irv, MIN_T, {rows[i].d, rows[i].a, rows[i].read_not_write_bit}, dout);
      check(dout, {rows[i].ed, ACK_OK});
    end
    check({3'h0, ctrl_stat}, {3'h0, CV});
    u_host.scan(3'h4, 0, {WV, 2'h1, 1'h0}, dout);
    check(dout, {32'h0, ACK_WAIT});
    ap_dly = 40;
    ap_rd = 32'h1234_5678;
    u_host.scan(3'h2, MIN_T, {32'h0, 2'h2, 1'h1}, dout);
    check(dout, {CV, ACK_OK});
    // Slow access port: the next scan lands while it is busy
    u_host.scan(3'h2, MIN_T, {WV, 2'h1, 1'h0}, dout);
    check(dout, {32'h0, ACK_WAIT});
    check({last_req.read_not_write_bit, last_req.addr, last_req.sel}, {1'h1, 2'h2, SV});
    u_host.scan(3'h4, 40, {32'h0, 2'h1, 1'h1}, dout);
    check(dout, {ap_rd, ACK_OK});
    u_host.scan(3'h4, MIN_T, {32'h0, 2'h3, 1'h1}, dout);
    check(dout, {CV | 32'h2, ACK_OK});
    u_host.scan(3'h2, MIN_T, {WV, 2'h0, 1'h0}, dout);
    check(dout, {32'h0, ACK_OK});
    u_host.scan(3'h4, 40, {CV | 32'h2, 2'h1, 1'h0}, dout);
    check(dout, {32'h0, ACK_OK});
    check({3'h0, ctrl_stat}, {3'h0, CV});
    check(35'(n_req), 35'h1);
    ap_err = 1'h1;
    ap_dly = 2;
    u_host.scan(3'h2, MIN_T, {WV, 2'h3, 1'h0}, dout);
    u_host.scan(3'h4, 40, {32'h0, 2'h1, 1'h1}, dout);
    check(dout, {32'h0, ACK_OK});
    check({last_req.read_not_write_bit, last_req.addr, last_req.wdata}, {1'h0, 2'h3, WV});
    u_host.scan(3'h4, MIN_T, {CV | 32'h30, 2'h1, 1'h0}, dout);
    check(dout, {CV | 32'h30, ACK_OK});
    // Access that never finishes, freed by a cancel scan
    ap_err = 1'h0;
    ap_dly = 100000;
    u_host.scan(3'h2, MIN_T, {32'h0, 2'h1, 1'h1}, dout);
    u_host.scan(3'h1, MIN_T, 35'h8, dout);
    u_host.scan(3'h4, 40, {32'h0, 2'h1, 1'h1}, dout);
    check({32'h0, dout[2:0]}, {32'h0, ACK_OK});
    check({33'h0, n_cncl == 1, ap_req_valid}, 35'h2);
    check(35'(n_req), 35'h3);
    // Mid-run reset while the link clock stands still
    @(posedge clk);
    nrst <= 1'h0;
    repeat (6) @(posedge clk);
    #37;
    check({test_data_out_pin, ap_req_valid, ap_cancel, ctrl_stat}, 35'h0);
    @(posedge clk);
    nrst <= 1'h1;
    repeat (3) @(posedge clk);
    u_host.scan(3'h4, 0, {32'h0, 2'h1, 1'h1}, dout);
    check(dout, {32'h0, ACK_OK});
    finish_test();
  end
endmodule  // tb_jdra_top
bind jdra_top jdra_chk u_chk (.clk, .nrst, .tck, .tap, .ir, .test_data_out_pin, .ctrl_stat, .ap_req_valid,
  .ap_req, .ap_done, .ap_cancel);

// >>> logic/jdra_pkg.sv
package jdra_pkg;
  // Scan chain geometry
  localparam int DATA_W = 32;
  localparam int CHAIN_W = 35;
  localparam int ACK_W = 3;
  localparam int CHAIN_RNW = 0;
  localparam int CHAIN_ADDR_LO = 1;
  localparam int CHAIN_DATA_LO = 3;
  localparam int CHAIN_CANCEL = 3;

  // Acknowledge codes
  localparam logic [2:0] ACK_OK = 3'h2;
  localparam logic [2:0] ACK_WAIT = 3'h1;

  // Debug port register addresses
  localparam logic [1:0] DP_ADDR_RSV = 2'h0;
  localparam logic [1:0] DP_ADDR_CTRL = 2'h1;
  localparam logic [1:0] DP_ADDR_SEL = 2'h2;
  localparam logic [1:0] DP_ADDR_RDBUF = 2'h3;

  // Control/status field positions
  localparam int CTRL_ORUN_DET = 0;
  localparam int CTRL_STK_ORUN = 1;
  localparam int CTRL_PUSH_LO = 2;
  localparam int CTRL_STK_CMP = 4;
  localparam int CTRL_STK_ERR = 5;
  localparam logic [1:0] PUSH_OFF = 2'h0;

  localparam logic [31:0] CTRL_RESET = 32'h00000000;
  localparam logic [31:0] SEL_RESET = 32'h00000000;
  localparam logic [31:0] ZERO_WORD = 32'h00000000;

  // Default least count of test-clock cycles from launch to answer
  localparam int MIN_TCK_DEF = 1;

  typedef struct packed {
    logic capture;
    logic shift;
    logic update;
  } jdra_tap_t;

  typedef struct packed {
    logic debug_port_access_chain;
    logic access_port_access_chain;
    logic cancel;
  } jdra_ir_t;

  typedef struct packed {
    logic read_not_write_bit;
    logic [1:0] addr;
    logic [31:0] sel;
    logic [31:0] wdata;
    logic [1:0] pushed;
  } jdra_ap_req_t;

  typedef struct packed {
    logic [31:0] rdata;
    logic err;
    logic cmp_fail;
  } jdra_ap_rsp_t;

  typedef enum {AP_IDLE, AP_BUSY} jdra_ap_state_t;
endpackage

// >>> logic/jdra_sync.sv
`timescale 1ns/100ps
// Two-stage level synchroniser; the first stage feeds only the second
module jdra_sync (
  input wire logic clk,
  input wire logic nrst,
  input wire logic d,
  output logic q
);
  logic meta_r;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta_r <= 1'b0;
      q <= 1'b0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule // jdra_sync

// >>> logic/jdra_top.sv
`timescale 1ns/100ps
// Operation
// - Launch at update, answer at next capture
// - Idle test-clock cycles between scans allowed
// - Capture before least count answers wait
// - Result bits 34..3, acknowledge bits 2..0
// - DP answer independent of current request
// - Busy access port gives wait, data unpredictable
// - Busy-port wait with overrun detect sets overrun flag
// - Only OK-acknowledged scans become previous request
// - DP read returns ctrl, select or zero
// - DP write stores ctrl or select, ignores 3
// - Clean AP read returns register value
// - AP write or pushed operation performed
// - AP error sets sticky error flag
// - Sticky flag set discards AP request
// - Cancel instruction selects 35-bit cancel chain
// - Acknowledge OK is 010, wait 001
// - No launch after a wait scan
// - Read/write bit 0 writes, 1 reads
module jdra_top #(
  parameter int MIN_TCK = jdra_pkg::MIN_TCK_DEF
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic tck,
  input wire jdra_pkg::jdra_tap_t tap,
  input wire jdra_pkg::jdra_ir_t ir,
  input wire logic test_data_in_pin,
  output logic test_data_out_pin,
  output logic [31:0] ctrl_stat,
  output logic ap_req_valid,
  output jdra_pkg::jdra_ap_req_t ap_req,
  input wire logic ap_done,
  input wire jdra_pkg::jdra_ap_rsp_t ap_rsp,
  output logic ap_cancel
);
  import jdra_pkg::*;

  localparam int CNT_W = (MIN_TCK < 1) ? 1 : $clog2(MIN_TCK + 1);
  localparam logic [CNT_W-1:0] MIN_CNT = CNT_W'(MIN_TCK);

  // Refuse least counts below zero or above 65535
  if (MIN_TCK < 0 || MIN_TCK > 65535) begin : g_bad_min_tck
    $error("MIN_TCK out of range");
  end

  // Test-clock domain state
  logic [CHAIN_W-1:0] sr_r;
  logic wait_r;
  logic prev_ap_r;
  logic prev_rnw_r;
  logic [1:0] prev_addr_r;
  logic prev_drop_r;
  logic [31:0] ctrl_r;
  logic [31:0] ctrl_nxt;
  logic [31:0] sel_r;
  jdra_ap_req_t launch_r;
  logic req_tgl_r;
  logic cancel_tgl_r;
  logic ack_seen_r;
  logic [CNT_W-1:0] min_cnt_r;

  // System-clock domain state
  jdra_ap_state_t ap_state_r;
  jdra_ap_req_t ap_req_r;
  jdra_ap_rsp_t rsp_r;
  logic ap_valid_r;
  logic ap_cancel_r;
  logic ack_tgl_r;
  logic req_seen_r;
  logic cancel_seen_r;

  // Crossings
  logic req_sync;
  logic cancel_sync;
  logic ack_sync;

  jdra_sync u_req_sync (
    .clk(clk),
    .nrst(nrst),
    .d(req_tgl_r),
    .q(req_sync)
  );

  jdra_sync u_cancel_sync (
    .clk(clk),
    .nrst(nrst),
    .d(cancel_tgl_r),
    .q(cancel_sync)
  );

  jdra_sync u_ack_sync (
    .clk(tck),
    .nrst(nrst),
    .d(ack_tgl_r),
    .q(ack_sync)
  );

  // Test-clock domain decode
  logic acc_ir;
  logic ap_busy;
  logic done_evt;
  logic too_soon;
  logic resp_wait;
  logic any_sticky;
  logic launch;
  logic [31:0] din;
  logic [1:0] a_in;
  logic rnw_in;
  logic [31:0] rd_result;

  assign acc_ir = ir.debug_port_access_chain | ir.access_port_access_chain;
  // Busy from launch until the answer's toggle has crossed back
  assign ap_busy = req_tgl_r ^ ack_sync;
  assign done_evt = ack_sync ^ ack_seen_r;
  // A least count of zero keeps this low, so no scan waits on it
  assign too_soon = min_cnt_r < MIN_CNT;
  assign resp_wait = ap_busy | too_soon;
  assign any_sticky = ctrl_r[CTRL_STK_ORUN] | ctrl_r[CTRL_STK_CMP] | ctrl_r[CTRL_STK_ERR];
  assign din = sr_r[CHAIN_DATA_LO +: DATA_W];
  assign a_in = sr_r[CHAIN_ADDR_LO +: 2];
  assign rnw_in = sr_r[CHAIN_RNW];
  // Requests shifted in during a wait scan never launch
  assign launch = tap.update & acc_ir & ~wait_r;

  // Result word depends only on the recorded previous request
  // Unpredictable data is returned as zero
  always_comb begin
    rd_result = ZERO_WORD;
    if (!prev_ap_r) begin
      if (prev_rnw_r) begin
        unique case (prev_addr_r)
          DP_ADDR_CTRL: rd_result = ctrl_r;
          DP_ADDR_SEL: rd_result = sel_r;
          DP_ADDR_RDBUF: rd_result = ZERO_WORD;
          DP_ADDR_RSV: rd_result = ZERO_WORD;
        endcase
      end
    end else if (prev_rnw_r && !prev_drop_r && !rsp_r.err) begin
      rd_result = rsp_r.rdata;
    end
  end

  // Scan chain: capture, shift LSB first
  always_ff @(posedge tck or negedge nrst) begin
    if (!nrst) begin
      sr_r <= '0;
    end else if (tap.capture) begin
      if (acc_ir) begin
        if (resp_wait) begin
          sr_r <= {ZERO_WORD, ACK_WAIT};
        end else begin
          sr_r <= {rd_result, ACK_OK};
        end
      end else begin
        sr_r <= '0;
      end
    end else if (tap.shift) begin
      sr_r <= {test_data_in_pin, sr_r[CHAIN_W-1:1]};
    end
  end

  assign test_data_out_pin = sr_r[0];

  // Acknowledge of the latest access scan steers the next update
  always_ff @(posedge tck or negedge nrst) begin
    if (!nrst) begin
      wait_r <= 1'b0;
    end else if (tap.capture && acc_ir) begin
      wait_r <= resp_wait;
    end
  end

  // Previous request record, replaced only by accepted scans
  always_ff @(posedge tck or negedge nrst) begin
    if (!nrst) begin
      prev_ap_r <= 1'b0;
      prev_rnw_r <= 1'b1;
      prev_addr_r <= DP_ADDR_RSV;
      prev_drop_r <= 1'b0;
    end else if (launch) begin
      prev_ap_r <= ir.access_port_access_chain;
      prev_rnw_r <= rnw_in;
      prev_addr_r <= a_in;
      prev_drop_r <= ir.access_port_access_chain & any_sticky;
    end
  end

  // Least count counts test-clock edges only, so idle spins add to it
  always_ff @(posedge tck or negedge nrst) begin
    if (!nrst) begin
      min_cnt_r <= MIN_CNT;
    end else if (launch) begin
      min_cnt_r <= '0;
    end else if (too_soon) begin
      min_cnt_r <= min_cnt_r + 1'b1;
    end
  end

  // Control/status: sticky bits clear by writing one; a set wins
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (launch && ir.debug_port_access_chain && !rnw_in && a_in == DP_ADDR_CTRL) begin
      ctrl_nxt = din;
      ctrl_nxt[CTRL_STK_ORUN] = ctrl_r[CTRL_STK_ORUN] & ~din[CTRL_STK_ORUN];
      ctrl_nxt[CTRL_STK_CMP] = ctrl_r[CTRL_STK_CMP] & ~din[CTRL_STK_CMP];
      ctrl_nxt[CTRL_STK_ERR] = ctrl_r[CTRL_STK_ERR] & ~din[CTRL_STK_ERR];
    end
    if (tap.capture && acc_ir && ap_busy && ctrl_r[CTRL_ORUN_DET]) begin
      ctrl_nxt[CTRL_STK_ORUN] = 1'b1;
    end
    if (done_evt && rsp_r.err) begin
      ctrl_nxt[CTRL_STK_ERR] = 1'b1;
    end
    if (done_evt && rsp_r.cmp_fail) begin
      ctrl_nxt[CTRL_STK_CMP] = 1'b1;
    end
  end

  always_ff @(posedge tck or negedge nrst) begin
    if (!nrst) begin
      ctrl_r <= CTRL_RESET;
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end

  assign ctrl_stat = ctrl_r;

  // Access-select register
  always_ff @(posedge tck or negedge nrst) begin
    if (!nrst) begin
      sel_r <= SEL_RESET;
    end else if (launch && ir.debug_port_access_chain && !rnw_in && a_in == DP_ADDR_SEL) begin
      sel_r <= din;
    end
  end

  // AP launch: words held stable until the acknowledge toggle returns
  always_ff @(posedge tck or negedge nrst) begin
    if (!nrst) begin
      launch_r <= '0;
      req_tgl_r <= 1'b0;
    end else if (launch && ir.access_port_access_chain && !any_sticky) begin
      launch_r.read_not_write_bit <= rnw_in;
      launch_r.addr <= a_in;
      launch_r.sel <= sel_r;
      launch_r.wdata <= din;
      launch_r.pushed <= ctrl_r[CTRL_PUSH_LO +: 2];
      req_tgl_r <= ~req_tgl_r;
    end
  end

  // Edge of the returned toggle marks when the response may be read
  always_ff @(posedge tck or negedge nrst) begin
    if (!nrst) begin
      ack_seen_r <= 1'b0;
    end else begin
      ack_seen_r <= ack_sync;
    end
  end

  // Cancel chain: only the cancel bit acts, other patterns are unspecified
  // Limitation: a cancel that arrives before the request is taken is lost
  always_ff @(posedge tck or negedge nrst) begin
    if (!nrst) begin
      cancel_tgl_r <= 1'b0;
    end else if (tap.update && ir.cancel && sr_r[CHAIN_CANCEL]) begin
      cancel_tgl_r <= ~cancel_tgl_r;
    end
  end

  // System-clock side of the access port handshake
  // The response word is read in tck only after its toggle crossed, so it is stable
  logic new_req;
  logic cancel_evt;

  assign new_req = req_sync ^ req_seen_r;
  assign cancel_evt = cancel_sync ^ cancel_seen_r;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      req_seen_r <= 1'b0;
      cancel_seen_r <= 1'b0;
    end else begin
      req_seen_r <= req_sync;
      cancel_seen_r <= cancel_sync;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ap_state_r <= AP_IDLE;
      ap_valid_r <= 1'b0;
      ap_req_r <= '0;
      rsp_r <= '0;
      ack_tgl_r <= 1'b0;
    end else begin
      unique case (ap_state_r)
        AP_IDLE: begin
          if (new_req) begin
            ap_req_r <= launch_r;
            ap_valid_r <= 1'b1;
            ap_state_r <= AP_BUSY;
          end
        end
        AP_BUSY: begin
          if (cancel_evt) begin
            // A cancelled access answers clean so the port frees at once
            ap_valid_r <= 1'b0;
            rsp_r <= '0;
            ack_tgl_r <= ~ack_tgl_r;
            ap_state_r <= AP_IDLE;
          end else if (ap_done) begin
            ap_valid_r <= 1'b0;
            rsp_r <= ap_rsp;
            ack_tgl_r <= ~ack_tgl_r;
            ap_state_r <= AP_IDLE;
          end
        end
      endcase
    end
  end

  // One-clock cancel pulse; the access port must free its interface
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ap_cancel_r <= 1'b0;
    end else begin
      ap_cancel_r <= cancel_evt;
    end
  end

  // Outputs come straight from registers
  assign ap_req_valid = ap_valid_r;
  assign ap_req = ap_req_r;
  assign ap_cancel = ap_cancel_r;
endmodule // jdra_top
